// file: easlr_pkg.sv
`default_nettype none

package easlr_pkg;

    // ==========================================================
    // command codes and selectors
    localparam logic [7:0] CMD_EAS_ALARM   = 8'ha5;
    localparam logic [7:0] CMD_PROT_EAS    = 8'ha6;
    localparam logic [7:0] CMD_WR_EAS_ID   = 8'ha7;
    localparam logic [7:0] CMD_LONG_RANGE  = 8'h40;
    localparam logic [7:0] SEL_EAS         = 8'h00;
    localparam logic [7:0] SEL_UID         = 8'h01;
    localparam logic [7:0] SEL_PC          = 8'h02;

    // ==========================================================
    // request layout
    localparam int         FLG_ADDR_BIT    = 5;
    localparam int         FLG_OPT_BIT     = 6;
    localparam logic [4:0] HDR_LEN         = 5'h03;
    localparam logic [4:0] HDR_ADDR_LEN    = 5'h0b;
    localparam logic [4:0] LR_REQ_LEN      = 5'h04;
    localparam logic [4:0] RX_IDX_MAX      = 5'h1f;
    localparam logic [7:0] MASK_LEN_NONE   = 8'h00;
    localparam logic [7:0] MASK_LEN_ONE    = 8'h08;
    localparam logic [7:0] MASK_LEN_TWO    = 8'h10;

    // ==========================================================
    // response fields
    localparam logic [7:0]  RSP_FLAGS_OK    = 8'h00;
    localparam logic [7:0]  RSP_FLAGS_ERR   = 8'h01;
    localparam logic [7:0]  ERR_CODE_DENIED = 8'h0f;
    localparam logic [15:0] EAS_ID_RST      = 16'h0000;
    localparam logic [5:0]  LAST_OK         = 6'h00;
    localparam logic [5:0]  LAST_ERR        = 6'h01;
    localparam logic [5:0]  LAST_EAS_ID     = 6'h02;
    localparam logic [5:0]  LAST_UID        = 6'h07;
    localparam logic [5:0]  LAST_EAS_SEQ    = 6'h1f;
    localparam logic [5:0]  LAST_EAS_SEQ_PF = 6'h20;
    localparam logic [15:0] LFSR_SEED       = 16'hace1;
    localparam logic [15:0] LFSR_TAPS       = 16'hb400;

    typedef enum logic [2:0] {
        K_EAS_SEQ,
        K_EAS_ID,
        K_UID,
        K_PC,
        K_FLAGS_OK,
        K_FLAGS_ERR
    } easlr_kind_t;

    // sequence bytes, first-sent bit in bit 0
    localparam logic [7:0] EAS_SEQ [32] = '{
        8'h2f, 8'hb3, 8'h62, 8'h70, 8'hd5, 8'ha7, 8'h90, 8'h7f,
        8'he8, 8'hb1, 8'h80, 8'h38, 8'hd2, 8'h81, 8'h49, 8'h76,
        8'h82, 8'hda, 8'h9a, 8'h86, 8'h6f, 8'haf, 8'h8b, 8'hb0,
        8'hf1, 8'h9c, 8'hd1, 8'h12, 8'ha5, 8'h72, 8'h37, 8'hef
    };

    // slot-count code to {valid, slot mask}
    function automatic logic [10:0] slot_decode(input logic [7:0] code);
        case (code)
            8'h10:   slot_decode = {1'b1, 10'h000};
            8'h20:   slot_decode = {1'b1, 10'h003};
            8'h40:   slot_decode = {1'b1, 10'h007};
            8'h80:   slot_decode = {1'b1, 10'h00f};
            8'h00:   slot_decode = {1'b1, 10'h01f};
            8'h01:   slot_decode = {1'b1, 10'h03f};
            8'h02:   slot_decode = {1'b1, 10'h07f};
            8'h04:   slot_decode = {1'b1, 10'h0ff};
            8'h08:   slot_decode = {1'b1, 10'h1ff};
            default: slot_decode = {1'b0, 10'h000};
        endcase
    endfunction

endpackage

`default_nettype wire

// file: easlr_seq_rom.sv
`timescale 1ns/1ps
`default_nettype none

module easlr_seq_rom
    import easlr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       ce,
    input  wire logic [4:0] addr,
    output var  logic [7:0] rd_data_reg
);

    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            rd_data_reg <= EAS_SEQ[addr];
        end
    end

endmodule

`default_nettype wire

// file: easlr_cmd.sv
`timescale 1ns/1ps
`default_nettype none

module easlr_cmd
    import easlr_pkg::*;
#(
    parameter int PC_BYTES = 12
)
(
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    input  wire logic                  ce,
    input  wire logic                  frame_start,
    input  wire logic                  long_range_request_start,
    input  wire logic                  rx_valid,
    input  wire logic [7:0]            rx_byte,
    input  wire logic                  frame_end,
    input  wire logic                  frame_crc_ok,
    input  wire logic                  long_range_request_end,
    input  wire logic                  eas_mode_en,
    input  wire logic                  eas_lock,
    input  wire logic                  eas_pwd_ok,
    input  wire logic                  pc_destroyed,
    input  wire logic [63:0]           uid,
    input  wire logic [PC_BYTES*8-1:0] pc_code,
    input  wire logic                  tx_ready,
    output var  logic                  tx_start_reg,
    output var  logic                  tx_lr_coding_reg,
    output var  logic [9:0]            tx_slot_reg,
    output var  logic                  tx_valid_reg,
    output var  logic [7:0]            tx_byte_reg,
    output var  logic                  tx_last_reg,
    output var  logic                  eas_prot_reg,
    output var  logic [15:0]           eas_id_reg,
    output var  logic                  eas_id_wr_reg
);

    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_LOAD, ST_SEND} easlr_state_t;

    // ==========================================================
    // request capture
    logic        rx_lr_reg;
    logic [4:0]  rx_idx_reg;
    logic [7:0]  rx_flags_reg;
    logic [7:0]  rx_cmd_reg;
    logic [7:0]  rx_p0_reg;
    logic [7:0]  rx_p1_reg;
    logic [7:0]  rx_p2_reg;
    logic [4:0]  hdr_len;
    logic [4:0]  prm_pos;

    assign hdr_len = rx_flags_reg[FLG_ADDR_BIT] ? HDR_ADDR_LEN : HDR_LEN;
    assign prm_pos = rx_lr_reg ? (rx_idx_reg - 5'h01) : (rx_idx_reg - hdr_len);

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            rx_lr_reg    <= 1'b0;
            rx_idx_reg   <= 5'h00;
            rx_flags_reg <= 8'h00;
            rx_cmd_reg   <= 8'h00;
            rx_p0_reg    <= 8'h00;
            rx_p1_reg    <= 8'h00;
            rx_p2_reg    <= 8'h00;
        end
        else if (ce)
        begin
            if (frame_start || long_range_request_start)
            begin
                rx_lr_reg  <= long_range_request_start;
                rx_idx_reg <= 5'h00;
            end
            else if (rx_valid)
            begin
                if (rx_idx_reg != RX_IDX_MAX)
                begin
                    rx_idx_reg <= rx_idx_reg + 5'h01;
                end
                if (!rx_lr_reg && rx_idx_reg == 5'h00)
                begin
                    rx_flags_reg <= rx_byte;
                end
                if (rx_idx_reg == (rx_lr_reg ? 5'h00 : 5'h01))
                begin
                    rx_cmd_reg <= rx_byte;
                end
                if (rx_lr_reg || rx_idx_reg >= hdr_len)
                begin
                    case (prm_pos)
                        5'h00:   rx_p0_reg <= rx_byte;
                        5'h01:   rx_p1_reg <= rx_byte;
                        5'h02:   rx_p2_reg <= rx_byte;
                        default: ;
                    endcase
                end
            end
        end
    end

    // ==========================================================
    // command decode
    easlr_state_t st_reg;
    easlr_kind_t  kind_reg;
    easlr_kind_t  kind_next;
    logic         go;
    logic         pfx_next;
    logic [5:0]   last_next;
    logic         lr_next;
    logic         set_prot;
    logic         wr_id;
    logic         std_end;
    logic         lr_end;
    logic         xor_ok;
    logic         alarm_opt;
    logic         alarm_match;
    logic         alarm_go;
    logic         id_write_ok;
    logic [10:0]  slot_dec;
    logic [15:0]  lfsr_reg;

    assign std_end   = ce && frame_end && frame_crc_ok && !rx_lr_reg && st_reg == ST_IDLE && rx_idx_reg >= HDR_LEN;
    assign lr_end    = ce && long_range_request_end && rx_lr_reg && st_reg == ST_IDLE && rx_idx_reg == LR_REQ_LEN;
    assign xor_ok    = (rx_cmd_reg ^ rx_p0_reg ^ rx_p1_reg) == rx_p2_reg;
    assign alarm_opt = rx_flags_reg[FLG_OPT_BIT];
    assign slot_dec  = slot_decode(rx_p1_reg);
    // a lock freezes the id, even with a good password
    assign id_write_ok = !eas_lock && (!eas_prot_reg || eas_pwd_ok);

    always_comb
    begin
        case (rx_p0_reg)
            MASK_LEN_NONE: alarm_match = 1'b1;
            MASK_LEN_ONE:  alarm_match = rx_p1_reg == eas_id_reg[7:0];
            MASK_LEN_TWO:  alarm_match = {rx_p2_reg, rx_p1_reg} == eas_id_reg;
            default:       alarm_match = 1'b0;
        endcase
    end

    assign alarm_go = eas_mode_en && (!alarm_opt || alarm_match);

    always_comb
    begin
        go        = 1'b0;
        kind_next = K_FLAGS_OK;
        pfx_next  = 1'b0;
        last_next = LAST_OK;
        lr_next   = 1'b0;
        set_prot  = 1'b0;
        wr_id     = 1'b0;
        if (std_end)
        begin
            case (rx_cmd_reg)
                CMD_EAS_ALARM:
                begin
                    go       = alarm_go;
                    pfx_next = 1'b1;
                    if (alarm_opt && rx_p0_reg == MASK_LEN_NONE)
                    begin
                        kind_next = K_EAS_ID;
                        last_next = LAST_EAS_ID;
                    end
                    else
                    begin
                        kind_next = K_EAS_SEQ;
                        last_next = LAST_EAS_SEQ_PF;
                    end
                end
                CMD_PROT_EAS:
                begin
                    go        = 1'b1;
                    set_prot  = eas_pwd_ok;
                    kind_next = eas_pwd_ok ? K_FLAGS_OK : K_FLAGS_ERR;
                    last_next = eas_pwd_ok ? LAST_OK : LAST_ERR;
                end
                CMD_WR_EAS_ID:
                begin
                    go        = 1'b1;
                    wr_id     = id_write_ok;
                    kind_next = id_write_ok ? K_FLAGS_OK : K_FLAGS_ERR;
                    last_next = id_write_ok ? LAST_OK : LAST_ERR;
                end
                default: ;
            endcase
        end
        else if (lr_end && xor_ok && rx_cmd_reg == CMD_LONG_RANGE)
        begin
            lr_next = 1'b1;
            case (rx_p0_reg)
                SEL_EAS:
                begin
                    go        = eas_mode_en;
                    kind_next = K_EAS_SEQ;
                    last_next = LAST_EAS_SEQ;
                end
                SEL_UID:
                begin
                    go        = slot_dec[10];
                    kind_next = K_UID;
                    last_next = LAST_UID;
                end
                SEL_PC:
                begin
                    go        = slot_dec[10] && !pc_destroyed;
                    kind_next = K_PC;
                    last_next = 6'(PC_BYTES - 1);
                end
                default: ;
            endcase
        end
    end

    // ==========================================================
    // EAS state and slot source
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            eas_prot_reg  <= 1'b0;
            eas_id_reg    <= EAS_ID_RST;
            eas_id_wr_reg <= 1'b0;
        end
        else if (ce)
        begin
            eas_id_wr_reg <= wr_id;
            if (set_prot)
            begin
                eas_prot_reg <= 1'b1;
            end
            if (wr_id)
            begin
                eas_id_reg <= {rx_p1_reg, rx_p0_reg};
            end
        end
    end

    // free-running, so each command draws a fresh slot
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            lfsr_reg <= LFSR_SEED;
        end
        else if (ce)
        begin
            lfsr_reg <= {lfsr_reg[14:0], ^(lfsr_reg & LFSR_TAPS)};
        end
    end

    // ==========================================================
    // response sequencer
    logic       pfx_reg;
    logic [5:0] idx_reg;
    logic [5:0] last_reg;
    logic [7:0] rom_q;
    logic [7:0] byte_sel;

    easlr_seq_rom easlr_seq_rom_inst (
        .clk         (clk),
        .ce          (ce),
        .addr        (5'(idx_reg - {5'h00, pfx_reg})),
        .rd_data_reg (rom_q)
    );

    always_comb
    begin
        case (kind_reg)
            K_EAS_SEQ:   byte_sel = (pfx_reg && idx_reg == 6'h00) ? RSP_FLAGS_OK : rom_q;
            K_EAS_ID:    byte_sel = (idx_reg == 6'h00) ? RSP_FLAGS_OK :
                                    (idx_reg == 6'h01) ? eas_id_reg[7:0] : eas_id_reg[15:8];
            K_UID:       byte_sel = uid[8*idx_reg[2:0] +: 8];
            K_PC:        byte_sel = pc_code[8*idx_reg +: 8];
            K_FLAGS_ERR: byte_sel = (idx_reg == 6'h00) ? RSP_FLAGS_ERR : ERR_CODE_DENIED;
            default:     byte_sel = RSP_FLAGS_OK;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st_reg           <= ST_IDLE;
            kind_reg         <= K_FLAGS_OK;
            pfx_reg          <= 1'b0;
            idx_reg          <= 6'h00;
            last_reg         <= 6'h00;
            tx_start_reg     <= 1'b0;
            tx_lr_coding_reg <= 1'b0;
            tx_slot_reg      <= 10'h000;
            tx_valid_reg     <= 1'b0;
            tx_byte_reg      <= 8'h00;
            tx_last_reg      <= 1'b0;
        end
        else if (ce)
        begin
            tx_start_reg <= 1'b0;
            case (st_reg)
                ST_IDLE:
                begin
                    if (go)
                    begin
                        st_reg           <= ST_FETCH;
                        kind_reg         <= kind_next;
                        pfx_reg          <= pfx_next;
                        last_reg         <= last_next;
                        idx_reg          <= 6'h00;
                        tx_start_reg     <= 1'b1;
                        tx_lr_coding_reg <= lr_next;
                        // EAS and standard replies always use slot zero
                        tx_slot_reg      <= (kind_next == K_UID || kind_next == K_PC) ?
                                            (lfsr_reg[9:0] & slot_dec[9:0]) : 10'h000;
                    end
                end
                ST_FETCH:
                begin
                    st_reg <= ST_LOAD;
                end
                ST_LOAD:
                begin
                    st_reg       <= ST_SEND;
                    tx_valid_reg <= 1'b1;
                    tx_byte_reg  <= byte_sel;
                    tx_last_reg  <= idx_reg == last_reg;
                end
                ST_SEND:
                begin
                    if (tx_ready)
                    begin
                        tx_valid_reg <= 1'b0;
                        tx_last_reg  <= 1'b0;
                        if (idx_reg == last_reg)
                        begin
                            st_reg <= ST_IDLE;
                        end
                        else
                        begin
                            idx_reg <= idx_reg + 6'h01;
                            st_reg  <= ST_FETCH;
                        end
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst || !ce);

    sequence seq_alarm_req;
        std_end && rx_cmd_reg == CMD_EAS_ALARM;
    endsequence

    sequence seq_lr_req;
        lr_end && rx_cmd_reg == CMD_LONG_RANGE && xor_ok;
    endsequence

    AST_ALARM_ID_REPLY: assert property (
        seq_alarm_req ##0 (eas_mode_en && alarm_opt && rx_p0_reg == MASK_LEN_NONE)
        |=> tx_start_reg && kind_reg == K_EAS_ID && last_reg == LAST_EAS_ID)
        else $error("alarm with empty mask did not return the id");
    AST_EAS_OFF_SILENT: assert property (
        seq_alarm_req ##0 !eas_mode_en |=> !tx_start_reg [*2])
        else $error("alarm answered while EAS mode off");
    AST_PROT_SET: assert property (
        (std_end && rx_cmd_reg == CMD_PROT_EAS && eas_pwd_ok) |=> eas_prot_reg && tx_start_reg)
        else $error("protection not enabled");
    AST_ID_STORED: assert property (
        (wr_id) |=> eas_id_reg == {$past(rx_p1_reg), $past(rx_p0_reg)} && eas_id_wr_reg)
        else $error("id write lost");
    AST_ID_REFUSED: assert property (
        (std_end && rx_cmd_reg == CMD_WR_EAS_ID && eas_prot_reg && !eas_pwd_ok)
        |=> kind_reg == K_FLAGS_ERR && last_reg == LAST_ERR && $stable(eas_id_reg))
        else $error("protected id write not refused");
    AST_XOR_BAD: assert property (
        (lr_end && !xor_ok) |=> !tx_start_reg)
        else $error("bad xor request answered");
    AST_EAS_ONE_SLOT: assert property (
        seq_lr_req ##0 (rx_p0_reg == SEL_EAS && eas_mode_en)
        |=> tx_slot_reg == 10'h000 && tx_lr_coding_reg ##2 tx_valid_reg && tx_byte_reg == EAS_SEQ[0])
        else $error("long-range EAS reply wrong");
    AST_SLOT_RANGE: assert property (
        seq_lr_req ##0 (rx_p0_reg == SEL_UID && slot_dec[10])
        |=> tx_slot_reg <= $past(slot_dec[9:0]) ##2 tx_byte_reg == uid[7:0])
        else $error("slot outside announced range");
    AST_PC_DESTROYED: assert property (
        seq_lr_req ##0 (rx_p0_reg == SEL_PC && pc_destroyed) |=> !tx_start_reg && st_reg == ST_IDLE)
        else $error("destroyed product code answered");
    AST_TX_HOLD: assert property (
        (tx_valid_reg && !tx_ready) |=> tx_valid_reg && $stable(tx_byte_reg) && $stable(tx_last_reg))
        else $error("tx byte changed before accept");

endmodule

`default_nettype wire

// file: easlr_reader_model.sv
`timescale 1ns/1ps
`default_nettype none

module easlr_reader_model
(
    input  wire logic       clk,
    input  wire logic       stall_en,
    output var  logic       frame_start,
    output var  logic       long_range_request_start,
    output var  logic       rx_valid,
    output var  logic [7:0] rx_byte,
    output var  logic       frame_end,
    output var  logic       frame_crc_ok,
    output var  logic       long_range_request_end,
    output var  logic       tx_ready
);
    logic [1:0] stall_cnt_reg = 2'h0;

    initial
    begin
        frame_start = 1'b0;
        long_range_request_start = 1'b0;
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        frame_end = 1'b0;
        frame_crc_ok = 1'b0;
        long_range_request_end = 1'b0;
        tx_ready = 1'b1;
    end

    // ==========================================================
    // framer side: slow mode accepts one cycle in four
    always @(posedge clk)
    begin
        stall_cnt_reg <= stall_cnt_reg + 2'h1;
        tx_ready <= !stall_en || (stall_cnt_reg == 2'h3);
    end

    // ==========================================================
    // one request frame; idle data line shows the inverse of the last byte
    task automatic send(input logic lr, input logic [7:0] b[$], input logic crc_ok);
        @(posedge clk);
        frame_start <= !lr;
        long_range_request_start <= lr;
        foreach (b[i])
        begin
            @(posedge clk);
            frame_start <= 1'b0;
            long_range_request_start <= 1'b0;
            rx_valid <= 1'b1;
            rx_byte <= b[i];
            @(posedge clk);
            rx_valid <= 1'b0;
            rx_byte <= ~b[i];
        end
        @(posedge clk);
        frame_end <= !lr;
        frame_crc_ok <= crc_ok;
        long_range_request_end <= lr;
        @(posedge clk);
        frame_end <= 1'b0;
        long_range_request_end <= 1'b0;
        frame_crc_ok <= !crc_ok;
    endtask
endmodule

`default_nettype wire

// file: easlr_cmd_tb.sv
`timescale 1ns/1ps
`default_nettype none

module easlr_cmd_tb
    import easlr_pkg::*;
;
    localparam int PCB = 4;
    logic clk = 1'b0, sys_rst, ce, eas_mode_en, eas_lock, eas_pwd_ok, pc_destroyed, stall_en;
    logic [63:0] uid;
    logic [PCB*8-1:0] pc_code;
    logic f_start, l_start, rx_valid, f_end, crc_ok, l_end, tx_ready;
    logic [7:0] rx_byte, tx_byte_reg;
    logic tx_start_reg, tx_lr_coding_reg, tx_valid_reg, tx_last_reg, eas_prot_reg, eas_id_wr_reg;
    logic [9:0] tx_slot_reg;
    logic [15:0] eas_id_reg, id, slot_hits = 16'h0000;
    logic [8:0] exp_bytes[$];
    logic [10:0] exp_starts[$];
    logic [7:0] seq[$], alarm_rsp[$], uidq[$], pcq[$], no_rsp[$], areq[$];
    logic [31:0] rnd_reg = 32'h0001_18ea;
    logic wr_seen = 1'b0;
    int mismatches = 0, total_checks = 0;

    always #25 clk = ~clk;

    easlr_reader_model reader_inst (.clk(clk), .stall_en(stall_en), .frame_start(f_start),
        .long_range_request_start(l_start), .rx_valid(rx_valid), .rx_byte(rx_byte), .frame_end(f_end),
        .frame_crc_ok(crc_ok), .long_range_request_end(l_end), .tx_ready(tx_ready));

    easlr_cmd #(.PC_BYTES(PCB)) easlr_cmd_inst (.clk(clk), .sys_rst(sys_rst), .ce(ce), .frame_start(f_start),
        .long_range_request_start(l_start), .rx_valid(rx_valid), .rx_byte(rx_byte), .frame_end(f_end),
        .frame_crc_ok(crc_ok), .long_range_request_end(l_end), .eas_mode_en(eas_mode_en),
        .eas_lock(eas_lock), .eas_pwd_ok(eas_pwd_ok), .pc_destroyed(pc_destroyed), .uid(uid),
        .pc_code(pc_code), .tx_ready(tx_ready), .tx_start_reg(tx_start_reg),
        .tx_lr_coding_reg(tx_lr_coding_reg), .tx_slot_reg(tx_slot_reg), .tx_valid_reg(tx_valid_reg),
        .tx_byte_reg(tx_byte_reg), .tx_last_reg(tx_last_reg), .eas_prot_reg(eas_prot_reg),
        .eas_id_reg(eas_id_reg), .eas_id_wr_reg(eas_id_wr_reg));

    // ==========================================================
    // helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // note the expected reply, send the request, wait for the reply to drain
    task automatic xfer(input logic lr, input logic [7:0] req[$], input logic crc, input logic [7:0] rsp[$],
                        input logic [9:0] mask);
        int n;
        if (rsp.size() > 0)
            exp_starts.push_back({lr, mask});
        foreach (rsp[i])
            exp_bytes.push_back({i == rsp.size() - 1, rsp[i]});
        reader_inst.send(lr, req, crc);
        n = 0;
        while ((exp_bytes.size() + exp_starts.size()) > 0 && n < 2000)
        begin
            @(posedge clk);
            n++;
        end
        // silence needs a margin past the reply start latency
        repeat (8) @(posedge clk);
        check("replies pending", 16'h0000, 16'(exp_bytes.size() + exp_starts.size()));
    endtask

    task automatic lr_req(input logic [7:0] sel, input logic [7:0] slots, input logic [7:0] rsp[$],
                          input logic [9:0] mask, input logic good);
        logic [7:0] x;
        x = CMD_LONG_RANGE ^ sel ^ slots;
        xfer(1'b1, '{CMD_LONG_RANGE, sel, slots, good ? x : ~x}, 1'b0, rsp, mask);
    endtask

    // ==========================================================
    // watcher: pops the oldest note whenever a result appears
    always @(posedge clk)
    begin
        if (eas_id_wr_reg === 1'b1)
            wr_seen = 1'b1;
        if (tx_start_reg === 1'b1)
        begin
            slot_hits[tx_slot_reg[3:0]] = 1'b1;
            if (exp_starts.size() == 0)
                check("unexpected reply", 16'h0000, 16'h0001);
            else
            begin
                check("lr coding", {15'h0000, exp_starts[0][10]}, {15'h0000, tx_lr_coding_reg});
                check("slot range", 16'h0000, {6'h00, tx_slot_reg & ~exp_starts[0][9:0]});
                void'(exp_starts.pop_front());
            end
        end
        if (tx_valid_reg === 1'b1 && tx_ready === 1'b1)
        begin
            if (exp_bytes.size() == 0)
                check("unexpected byte", 16'h0000, 16'h0001);
            else
                check("reply byte", {7'h00, exp_bytes.pop_front()}, {7'h00, tx_last_reg, tx_byte_reg});
        end
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        report_and_stop();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        {sys_rst, ce, eas_mode_en, eas_lock, eas_pwd_ok, pc_destroyed, stall_en} = 7'h60;
        for (int i = 0; i < 4; i++)
        begin
            rnd_reg = xs(rnd_reg);
            if (i < 2)
                uid[i*32 +: 32] = rnd_reg;
            else if (i == 2)
                pc_code = rnd_reg;
            else
                id = rnd_reg[15:0];
        end
        foreach (EAS_SEQ[i])
            seq.push_back(EAS_SEQ[i]);
        for (int i = 0; i < 8; i++)
            uidq.push_back(uid[i*8 +: 8]);
        for (int i = 0; i < PCB; i++)
            pcq.push_back(pc_code[i*8 +: 8]);
        alarm_rsp = seq;
        alarm_rsp.push_front(RSP_FLAGS_OK);
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        check("eas id reset", EAS_ID_RST, eas_id_reg);
        check("prot reset", 16'h0000, {15'h0000, eas_prot_reg});
        xfer(1'b0, '{8'h00, CMD_EAS_ALARM, 8'h04}, 1'b1, no_rsp, 10'h000);
        xfer(1'b0, '{8'h40, CMD_EAS_ALARM, 8'h04, MASK_LEN_NONE}, 1'b1, no_rsp, 10'h000);
        lr_req(SEL_EAS, 8'h00, no_rsp, 10'h000, 1'b1);
        eas_mode_en <= 1'b1;
        ce <= 1'b0;
        xfer(1'b0, '{8'h40, CMD_EAS_ALARM, 8'h04, MASK_LEN_NONE}, 1'b1, no_rsp, 10'h000);
        ce <= 1'b1;
        xfer(1'b0, '{8'h00, CMD_WR_EAS_ID, 8'h04, id[7:0], id[15:8]}, 1'b1, '{RSP_FLAGS_OK}, 10'h000);
        check("eas id", id, eas_id_reg);
        check("id write pulse", 16'h0001, {15'h0000, wr_seen});
        stall_en <= 1'b1;
        xfer(1'b0, '{8'h40, CMD_EAS_ALARM, 8'h04, MASK_LEN_NONE}, 1'b1, '{RSP_FLAGS_OK, id[7:0], id[15:8]},
             10'h000);
        xfer(1'b0, '{8'h00, CMD_EAS_ALARM, 8'h04}, 1'b1, alarm_rsp, 10'h000);
        xfer(1'b0, '{8'h40, CMD_EAS_ALARM, 8'h04, MASK_LEN_ONE, id[7:0]}, 1'b1, alarm_rsp, 10'h000);
        xfer(1'b0, '{8'h40, CMD_EAS_ALARM, 8'h04, MASK_LEN_TWO, id[7:0], ~id[15:8]}, 1'b1, no_rsp, 10'h000);
        areq = uidq;
        areq.push_front(8'h04);
        areq.push_front(CMD_EAS_ALARM);
        areq.push_front(8'h60);
        areq.push_back(MASK_LEN_NONE);
        xfer(1'b0, areq, 1'b1, '{RSP_FLAGS_OK, id[7:0], id[15:8]}, 10'h000);
        xfer(1'b0, '{8'h00, CMD_PROT_EAS, 8'h04}, 1'b1, '{RSP_FLAGS_ERR, ERR_CODE_DENIED}, 10'h000);
        check("prot without password", 16'h0000, {15'h0000, eas_prot_reg});
        eas_pwd_ok <= 1'b1;
        xfer(1'b0, '{8'h00, CMD_PROT_EAS, 8'h04}, 1'b1, '{RSP_FLAGS_OK}, 10'h000);
        check("prot on", 16'h0001, {15'h0000, eas_prot_reg});
        eas_pwd_ok <= 1'b0;
        xfer(1'b0, '{8'h00, CMD_WR_EAS_ID, 8'h04, ~id[7:0], ~id[15:8]}, 1'b1,
             '{RSP_FLAGS_ERR, ERR_CODE_DENIED}, 10'h000);
        check("eas id kept", id, eas_id_reg);
        eas_pwd_ok <= 1'b1;
        stall_en <= 1'b0;
        xfer(1'b0, '{8'h00, CMD_WR_EAS_ID, 8'h04, ~id[7:0], ~id[15:8]}, 1'b0, no_rsp, 10'h000);
        check("eas id after bad crc", id, eas_id_reg);
        eas_lock <= 1'b1;
        xfer(1'b0, '{8'h00, CMD_WR_EAS_ID, 8'h04, ~id[7:0], ~id[15:8]}, 1'b1,
             '{RSP_FLAGS_ERR, ERR_CODE_DENIED}, 10'h000);
        check("eas id locked", id, eas_id_reg);
        eas_lock <= 1'b0;
        lr_req(SEL_EAS, 8'h00, seq, 10'h000, 1'b1);
        lr_req(SEL_EAS, 8'h80, seq, 10'h000, 1'b1);
        lr_req(SEL_EAS, 8'h00, no_rsp, 10'h000, 1'b0);
        lr_req(SEL_UID, 8'h10, uidq, 10'h000, 1'b1);
        slot_hits = 16'h0000;
        for (int k = 0; k < 6; k++)
            lr_req(SEL_UID, 8'h80, uidq, 10'h00f, 1'b1);
        check("slot varies", 16'h0001, {15'h0000, $countones(slot_hits) > 1});
        lr_req(SEL_PC, 8'h40, pcq, 10'h007, 1'b1);
        pc_destroyed <= 1'b1;
        lr_req(SEL_PC, 8'h40, no_rsp, 10'h000, 1'b1);
        report_and_stop();
    end
endmodule

`default_nettype wire
